// ==== rtl/cfgr_pkg.sv ====
// constants, types and carriers for the filter, detection and input gain register group
package cfgr_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int ADDR_W = 7;
  localparam logic [6:0] OFS_FILT = 7'h0C;
  localparam logic [6:0] OFS_RSVD = 7'h0D;
  localparam logic [6:0] OFS_DET = 7'h0E;
  localparam logic [6:0] OFS_LPGA = 7'h0F;
  localparam logic [6:0] OFS_RPGA = 7'h10;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] FILT_RST = 8'h00;
  localparam logic [7:0] RSVD_RST = 8'h00;
  localparam logic [7:0] DET_RST = 8'h00;
  localparam logic [7:0] PGA_RST = 8'h80;
  localparam logic [7:0] RD_ZERO = 8'h00;

  // ****************************************
  // field positions
  // ****************************************
  localparam int HPF_L_HI = 7;
  localparam int HPF_L_LO = 6;
  localparam int HPF_R_HI = 5;
  localparam int HPF_R_LO = 4;
  localparam int EFF_L_BIT = 3;
  localparam int DEEMP_L_BIT = 2;
  localparam int EFF_R_BIT = 1;
  localparam int DEEMP_R_BIT = 0;
  localparam int COUPLE_BIT = 7;
  localparam int FDIFF_BIT = 6;
  localparam int HSDET_BIT = 4;
  localparam int PDIFF_BIT = 3;
  localparam logic [7:0] DET_RW_MASK = 8'hC8;
  localparam int MUTE_BIT = 7;
  localparam int GAIN_HI = 6;

  // gain code in 0.5 dB steps, saturating at 59.5 dB
  localparam logic [6:0] GAIN_MAX = 7'h77;

  // high-pass corner in units of 0.0001 x adc sample rate
  localparam logic [7:0] HPF_COEF_OFF = 8'h00;
  localparam logic [7:0] HPF_COEF_0045 = 8'h2D;
  localparam logic [7:0] HPF_COEF_0125 = 8'h7D;
  localparam logic [7:0] HPF_COEF_0250 = 8'hFA;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    HPF_OFF,
    HPF_C0045,
    HPF_C0125,
    HPF_C0250
  } cfgr_hpf_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } cfgr_req_t;

  typedef struct packed {
    logic hpf_en;
    cfgr_hpf_t hpf_sel;
    logic [7:0] hpf_coef;
    logic mute;
    logic [6:0] gain_half_db;
  } cfgr_path_t;

  typedef struct packed {
    logic eff_en;
    logic deemp_en;
  } cfgr_dac_t;

  typedef struct packed {
    logic ac_coupled;
    logic fully_diff;
    logic pseudo_diff;
  } cfgr_drv_t;

endpackage

// ==== rtl/cfgr_adc_path.sv ====
// decode of one adc channel: high-pass corner, pga mute and saturated gain
`timescale 1ns/100ps
`default_nettype none
module cfgr_adc_path (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic [1:0] hpf_code,
  input wire logic [7:0] pga_reg,
  output var cfgr_pkg::cfgr_path_t path
);
  import cfgr_pkg::*;

  logic hpf_en_r;
  cfgr_hpf_t hpf_sel_r;
  logic [7:0] hpf_coef_r;
  logic mute_r;
  logic [6:0] gain_r;

  // one driver per field group, joined here
  assign path = '{hpf_en: hpf_en_r, hpf_sel: hpf_sel_r, hpf_coef: hpf_coef_r, mute: mute_r,
    gain_half_db: gain_r};

  // ****************************************
  // high-pass corner
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hpf_en_r <= 1'b0;
      hpf_sel_r <= HPF_OFF;
      hpf_coef_r <= HPF_COEF_OFF;
    end else begin
      hpf_en_r <= (cfgr_hpf_t'(hpf_code) != HPF_OFF);
      hpf_sel_r <= cfgr_hpf_t'(hpf_code);
      unique case (cfgr_hpf_t'(hpf_code))
        HPF_OFF: hpf_coef_r <= HPF_COEF_OFF;
        HPF_C0045: hpf_coef_r <= HPF_COEF_0045;
        HPF_C0125: hpf_coef_r <= HPF_COEF_0125;
        HPF_C0250: hpf_coef_r <= HPF_COEF_0250;
      endcase
    end
  end

  // ****************************************
  // pga mute and gain
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mute_r <= PGA_RST[MUTE_BIT];
      gain_r <= PGA_RST[GAIN_HI:0];
    end else begin
      mute_r <= pga_reg[MUTE_BIT];
      if (pga_reg[GAIN_HI:0] >= GAIN_MAX) begin
        gain_r <= GAIN_MAX;
      end else begin
        gain_r <= pga_reg[GAIN_HI:0];
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_hpf_off_map: assert property (@(posedge core_clk) disable iff (!arst_n)
    (hpf_code == 2'h0) |=> (!path.hpf_en && path.hpf_coef == HPF_COEF_OFF))
    else $error("hpf code zero did not disable the filter");

  a_hpf_top_corner: assert property (@(posedge core_clk) disable iff (!arst_n)
    (hpf_code == 2'h3) |=> (path.hpf_en && path.hpf_coef == HPF_COEF_0250))
    else $error("hpf code three did not select the top corner");

  a_gain_sat_clamp: assert property (@(posedge core_clk) disable iff (!arst_n)
    (pga_reg[6:0] >= 7'h77) |=> (path.gain_half_db == 7'h77))
    else $error("gain above top code did not saturate");

  a_gain_low_pass: assert property (@(posedge core_clk) disable iff (!arst_n)
    (pga_reg[6:0] < 7'h77) |=> (path.gain_half_db == $past(pga_reg[6:0])))
    else $error("gain below top code was not passed through");

endmodule
`default_nettype wire

// ==== rtl/cfgr_regs.sv ====
// filter control, output driver and headset detection, and adc pga gain register group
`timescale 1ns/100ps
`default_nettype none
module cfgr_regs (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire cfgr_pkg::cfgr_req_t req,
  input wire logic headset_det_pin,
  output logic [7:0] rdata,
  output logic rd_ack,
  output var cfgr_pkg::cfgr_path_t adc_left,
  output var cfgr_pkg::cfgr_path_t adc_right,
  output var cfgr_pkg::cfgr_dac_t dac_left,
  output var cfgr_pkg::cfgr_dac_t dac_right,
  output var cfgr_pkg::cfgr_drv_t drv,
  output logic headset_flag
);
  import cfgr_pkg::*;

  logic [7:0] filt_r;
  logic [7:0] rsvd_r;
  logic [7:0] det_r;
  logic [7:0] lpga_r;
  logic [7:0] rpga_r;
  logic hs_meta_r;
  logic hs_sync_r;
  logic [7:0] rdata_nxt;
  logic [7:0] det_view;

  // ****************************************
  // register writes
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      filt_r <= FILT_RST;
    end else if (req.wr && req.addr == OFS_FILT) begin
      filt_r <= req.wdata;
    end
  end

  // stored as written; host is expected to keep it zero
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rsvd_r <= RSVD_RST;
    end else if (req.wr && req.addr == OFS_RSVD) begin
      rsvd_r <= req.wdata;
    end
  end

  // only coupling and the two arrangement bits are writable
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      det_r <= DET_RST;
    end else if (req.wr && req.addr == OFS_DET) begin
      det_r <= req.wdata & DET_RW_MASK;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      lpga_r <= PGA_RST;
    end else if (req.wr && req.addr == OFS_LPGA) begin
      lpga_r <= req.wdata;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rpga_r <= PGA_RST;
    end else if (req.wr && req.addr == OFS_RPGA) begin
      rpga_r <= req.wdata;
    end
  end

  // ****************************************
  // headset detect synchroniser
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_meta_r <= 1'b0;
      hs_sync_r <= 1'b0;
      headset_flag <= 1'b0;
    end else begin
      hs_meta_r <= headset_det_pin;
      hs_sync_r <= hs_meta_r;
      headset_flag <= hs_sync_r;
    end
  end

  // ****************************************
  // read path
  // ****************************************
  always_comb begin
    det_view = det_r & DET_RW_MASK;
    det_view[HSDET_BIT] = headset_flag;
  end

  always_comb begin
    unique case (req.addr)
      OFS_FILT: rdata_nxt = filt_r;
      OFS_RSVD: rdata_nxt = rsvd_r;
      OFS_DET: rdata_nxt = det_view;
      OFS_LPGA: rdata_nxt = lpga_r;
      OFS_RPGA: rdata_nxt = rpga_r;
      default: rdata_nxt = RD_ZERO;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= RD_ZERO;
      rd_ack <= 1'b0;
    end else begin
      rd_ack <= req.rd;
      if (req.rd) begin
        rdata <= rdata_nxt;
      end
    end
  end

  // ****************************************
  // dac filter and driver controls
  // ****************************************
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dac_left <= '0;
      dac_right <= '0;
    end else begin
      dac_left.eff_en <= filt_r[EFF_L_BIT];
      dac_left.deemp_en <= filt_r[DEEMP_L_BIT];
      dac_right.eff_en <= filt_r[EFF_R_BIT];
      dac_right.deemp_en <= filt_r[DEEMP_R_BIT];
    end
  end

  // both arrangement bits together is a host error and is passed on unchanged
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      drv <= '0;
    end else begin
      drv.ac_coupled <= det_r[COUPLE_BIT];
      drv.fully_diff <= det_r[FDIFF_BIT];
      drv.pseudo_diff <= det_r[PDIFF_BIT];
    end
  end

  // ****************************************
  // adc channels
  // ****************************************
  cfgr_adc_path u_left (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .hpf_code(filt_r[HPF_L_HI:HPF_L_LO]),
    .pga_reg(lpga_r),
    .path(adc_left)
  );

  cfgr_adc_path u_right (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .hpf_code(filt_r[HPF_R_HI:HPF_R_LO]),
    .pga_reg(rpga_r),
    .path(adc_right)
  );

  // ****************************************
  // checks
  // ****************************************
  sequence s_filt_write;
    req.wr && req.addr == 7'h0C;
  endsequence

  sequence s_pin_high;
    headset_det_pin [*3];
  endsequence

  sequence s_pin_low;
    !headset_det_pin [*3];
  endsequence

  sequence s_det_read;
    req.rd && req.addr == OFS_DET;
  endsequence

  sequence s_unmapped_write;
    req.wr && (req.addr < OFS_FILT || req.addr > OFS_RPGA);
  endsequence

  a_dac_ctrl_follow: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_filt_write ##2 1'b1 |-> (dac_left.eff_en == $past(req.wdata[3], 2)
      && dac_left.deemp_en == $past(req.wdata[2], 2)
      && dac_right.eff_en == $past(req.wdata[1], 2)
      && dac_right.deemp_en == $past(req.wdata[0], 2)))
    else $error("dac filter controls did not follow the filter register");

  a_filt_read_back: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_filt_write ##1 (req.rd && req.addr == 7'h0C && !req.wr) |=>
      (rd_ack && rdata == $past(req.wdata, 2)))
    else $error("filter register did not read back the written value");

  a_det_ro_bits: assert property (@(posedge core_clk) disable iff (!arst_n)
    (req.rd && req.addr == 7'h0E) |=> ((rdata & 8'h27) == 8'h00))
    else $error("reserved detection bits read non-zero");

  a_hsdet_rise: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_pin_high |=> headset_flag)
    else $error("headset flag missed a steady detect level");

  a_hsdet_fall: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_pin_low |=> !headset_flag)
    else $error("headset flag stayed set after detect level fell");

  a_coupling_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    (req.wr && req.addr == 7'h0E) |=> ##1 (drv.ac_coupled == $past(req.wdata[7], 2)
      && drv.fully_diff == $past(req.wdata[6], 2)
      && drv.pseudo_diff == $past(req.wdata[3], 2)))
    else $error("driver configuration did not follow the detection register");

  a_pga_mute_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    (req.wr && req.addr == 7'h0F) |=> ##1 (adc_left.mute == $past(req.wdata[7], 2)))
    else $error("left pga mute did not follow its register");

  a_rd_ack_pulse: assert property (@(posedge core_clk) disable iff (!arst_n)
    req.rd |=> rd_ack)
    else $error("read was not acknowledged in the next cycle");

  a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!arst_n)
    (req.rd && (req.addr < 7'h0C || req.addr > 7'h10)) |=> (rdata == 8'h00))
    else $error("unmapped read returned non-zero data");

  // ****************************************
  // output follow, storage and read port checks
  // ****************************************

  a_lhpf_follow: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_filt_write ##2 1'b1 |-> (adc_left.hpf_sel == $past(req.wdata[HPF_L_HI:HPF_L_LO], 2)))
    else $error("left hpf select did not follow the filter register");

  a_rhpf_follow: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_filt_write ##2 1'b1 |-> (adc_right.hpf_sel == $past(req.wdata[HPF_R_HI:HPF_R_LO], 2)))
    else $error("right hpf select did not follow the filter register");

  a_rpga_mute_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    (req.wr && req.addr == OFS_RPGA) |=> ##1 (adc_right.mute == $past(req.wdata[MUTE_BIT], 2)))
    else $error("right pga mute did not follow its register");

  a_filt_store: assert property (@(posedge core_clk) disable iff (!arst_n)
    (req.wr && req.addr == OFS_FILT) |=> (filt_r == $past(req.wdata)))
    else $error("filter register did not store the written value");

  a_rsvd_store: assert property (@(posedge core_clk) disable iff (!arst_n)
    (req.wr && req.addr == OFS_RSVD) |=> (rsvd_r == $past(req.wdata)))
    else $error("reserved register did not store the written value");

  a_det_store: assert property (@(posedge core_clk) disable iff (!arst_n)
    (req.wr && req.addr == OFS_DET) |=> (det_r == ($past(req.wdata) & DET_RW_MASK)))
    else $error("detection register stored a read-only bit");

  a_lpga_store: assert property (@(posedge core_clk) disable iff (!arst_n)
    (req.wr && req.addr == OFS_LPGA) |=> (lpga_r == $past(req.wdata)))
    else $error("left pga register did not store the written value");

  a_rpga_store: assert property (@(posedge core_clk) disable iff (!arst_n)
    (req.wr && req.addr == OFS_RPGA) |=> (rpga_r == $past(req.wdata)))
    else $error("right pga register did not store the written value");

  a_unmapped_write: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_unmapped_write |=> ($stable(filt_r) && $stable(rsvd_r) && $stable(det_r)
      && $stable(lpga_r) && $stable(rpga_r)))
    else $error("write to an unmapped address changed a register");

  a_rd_ack_idle: assert property (@(posedge core_clk) disable iff (!arst_n)
    !req.rd |=> !rd_ack)
    else $error("read acknowledge without a read");

  a_rdata_hold: assert property (@(posedge core_clk) disable iff (!arst_n)
    !req.rd |=> $stable(rdata))
    else $error("read data changed without a read");

  a_hs_read_view: assert property (@(posedge core_clk) disable iff (!arst_n)
    s_det_read |=> (rdata[HSDET_BIT] == $past(headset_flag)))
    else $error("detection read did not show the headset flag");

  a_rd_old_value: assert property (@(posedge core_clk) disable iff (!arst_n)
    (req.wr && req.rd && req.addr == OFS_FILT) |=> (rdata == $past(filt_r)))
    else $error("read beside a write did not return the old value");

endmodule
`default_nettype wire

// ==== sim/cfgr_host_model.sv ====
// host model issuing single-byte writes and reads on the register port
`timescale 1ns/100ps
`default_nettype none
module cfgr_host_model (
  input wire logic core_clk,
  output var cfgr_pkg::cfgr_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rd_ack
);
  import cfgr_pkg::*;

  initial req = '0;

  // raw set only where a test wants the device to see an illegal write
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic raw);
    logic [7:0] v;
    v = d;
    if (!raw && a == OFS_RSVD) v = 8'h00;
    if (!raw && a == OFS_DET) v = v & DET_RW_MASK;
    if (!raw && a == OFS_DET && v[6]) v[3] = 1'b0;
    @(posedge core_clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge core_clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ak);
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1;
    d = rdata;
    ak = rd_ack;
  endtask

  // write then read back to back, or both in one cycle; filter register only
  task automatic wr_rd(input logic [6:0] a, input logic [7:0] d, input logic same,
    output logic [7:0] q);
    @(posedge core_clk);
    req <= '{wr: 1'b1, rd: same, addr: a, wdata: d};
    if (!same) begin
      @(posedge core_clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    end
    @(posedge core_clk);
    req.wr <= 1'b0;
    req.rd <= 1'b0;
    #1;
    q = rdata;
  endtask
endmodule
`default_nettype wire

// ==== sim/tb.sv ====
// self-checking bench for the filter, detection and gain register group
`timescale 1ns/100ps
`default_nettype none
module tb;
  import cfgr_pkg::*;
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rexp;
  } cfgr_row_t;
  logic core_clk;
  logic arst_n;
  logic headset_det_pin;
  cfgr_req_t req;
  logic [7:0] rdata;
  logic rd_ack;
  cfgr_path_t adc_left;
  cfgr_path_t adc_right;
  cfgr_dac_t dac_left;
  cfgr_dac_t dac_right;
  cfgr_drv_t drv;
  logic headset_flag;
  int err_count;
  int cmp_count;
  logic [7:0] sh [5];
  logic [7:0] rd_q;
  cfgr_row_t rows [14];

  cfgr_regs cfgr_regs_i (.core_clk(core_clk), .arst_n(arst_n), .req(req),
    .headset_det_pin(headset_det_pin), .rdata(rdata), .rd_ack(rd_ack),
    .adc_left(adc_left), .adc_right(adc_right), .dac_left(dac_left),
    .dac_right(dac_right), .drv(drv), .headset_flag(headset_flag));

  cfgr_host_model cfgr_host_model_i (.core_clk(core_clk), .req(req), .rdata(rdata),
    .rd_ack(rd_ack));

  // ****************************************
  // checking helpers
  // ****************************************
  task automatic chk(input string name, input logic [18:0] seen, input logic [18:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  function automatic logic [7:0] coef(input logic [1:0] c);
    case (c)
      2'h1: return HPF_COEF_0045;
      2'h2: return HPF_COEF_0125;
      2'h3: return HPF_COEF_0250;
      default: return HPF_COEF_OFF;
    endcase
  endfunction

  function automatic logic [18:0] path(input logic [1:0] c, input logic [7:0] g);
    return {c != 2'h0, c, coef(c), g[7], (g[6:0] > GAIN_MAX) ? GAIN_MAX : g[6:0]};
  endfunction

  task automatic chk_outs();
    chk("adc_left", adc_left, path(sh[0][7:6], sh[3]));
    chk("adc_right", adc_right, path(sh[0][5:4], sh[4]));
    chk("dac_left", 19'(dac_left), 19'(sh[0][3:2]));
    chk("dac_right", 19'(dac_right), 19'(sh[0][1:0]));
    chk("drv", 19'(drv), 19'({sh[2][7], sh[2][6], sh[2][3]}));
  endtask

  // shadow keeps what the device should hold; outputs settle two edges later
  task automatic wr_chk(input logic [6:0] a, input logic [7:0] d, input logic raw);
    cfgr_host_model_i.wr(a, d, raw);
    if (a >= OFS_FILT && a <= OFS_RPGA) sh[a - OFS_FILT] = (a == OFS_DET) ? d & DET_RW_MASK : d;
    repeat (2) @(posedge core_clk);
    #1;
    chk_outs();
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
    logic [7:0] v;
    logic ak;
    cfgr_host_model_i.rd(a, v, ak);
    chk("rd_ack", 19'(ak), 19'h1);
    chk("rdata", 19'(v), 19'(exp));
  endtask

  task automatic rd_all();
    for (int i = 0; i < 5; i++) begin
      rd_chk(OFS_FILT + 7'(i), sh[i]);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ****************************************
  // clock and watchdog
  // ****************************************
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  initial begin
    #200000;
    err_count++;
    print_verdict();
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    arst_n = 1'b0;
    headset_det_pin = 1'b0;
    err_count = 0;
    cmp_count = 0;
    sh = '{FILT_RST, RSVD_RST, DET_RST, PGA_RST, PGA_RST};
    rows = '{'{OFS_FILT, 8'h00, 8'h00}, '{OFS_FILT, 8'h5A, 8'h5A}, '{OFS_FILT, 8'hA5, 8'hA5},
      '{OFS_FILT, 8'hFF, 8'hFF}, '{OFS_DET, 8'h80, 8'h80}, '{OFS_DET, 8'h40, 8'h40},
      '{OFS_DET, 8'h08, 8'h08}, '{OFS_LPGA, 8'h00, 8'h00}, '{OFS_LPGA, 8'h76, 8'h76},
      '{OFS_LPGA, 8'h77, 8'h77}, '{OFS_LPGA, 8'hF8, 8'hF8}, '{OFS_RPGA, 8'h7F, 8'h7F},
      '{OFS_RPGA, 8'h01, 8'h01}, '{OFS_RSVD, 8'h00, 8'h00}};
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    #1;
    chk_outs();
    rd_all();
    $display("test reset values done");
    foreach (rows[i]) begin
      wr_chk(rows[i].addr, rows[i].wdata, 1'b0);
      rd_chk(rows[i].addr, rows[i].rexp);
    end
    $display("test table done");
    wr_chk(OFS_DET, 8'h37, 1'b1);
    rd_chk(OFS_DET, 8'h00);
    wr_chk(7'h11, 8'hFF, 1'b1);
    rd_chk(7'h11, RD_ZERO);
    rd_all();
    $display("test refused writes done");
    @(posedge core_clk);
    headset_det_pin <= 1'b1;
    @(posedge core_clk);
    #1;
    chk("headset_flag", 19'(headset_flag), 19'h0);
    repeat (2) @(posedge core_clk);
    #1;
    chk("headset_flag", 19'(headset_flag), 19'h1);
    rd_chk(OFS_DET, 8'h10);
    @(posedge core_clk);
    headset_det_pin <= 1'b0;
    repeat (4) @(posedge core_clk);
    rd_chk(OFS_DET, 8'h00);
    $display("test headset flag done");
    cfgr_host_model_i.wr_rd(OFS_FILT, 8'h3C, 1'b0, rd_q);
    sh[0] = 8'h3C;
    chk("rdata", 19'(rd_q), 19'(sh[0]));
    cfgr_host_model_i.wr_rd(OFS_FILT, 8'hC3, 1'b1, rd_q);
    chk("rdata", 19'(rd_q), 19'(sh[0]));
    sh[0] = 8'hC3;
    rd_chk(OFS_FILT, sh[0]);
    chk_outs();
    $display("test back-to-back done");
    wr_chk(OFS_FILT, 8'h6C, 1'b0);
    wr_chk(OFS_DET, 8'hC0, 1'b0);
    @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    sh = '{FILT_RST, RSVD_RST, DET_RST, PGA_RST, PGA_RST};
    #1;
    chk_outs();
    rd_all();
    $display("test mid-run reset done");
    print_verdict();
  end
endmodule
`default_nettype wire
